// >>> hdl/spf_pkg.sv
package spf_pkg;
	// =========================================================
	// control register layout
	localparam int CTL_SELF_PROG_ENABLE_ALIAS = 0;
	localparam int CTL_PAGE_ERASE_BIT = 1;
	localparam int CTL_PAGE_WRITE_BIT = 2;
	localparam int CTL_READ_FUSE_LOCK_BIT = 3;
	localparam int CTL_CLEAR_PAGE_BUFFER_BIT = 4;
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_READ_FUSE_LOCK_BIT = 5'h09;
	localparam logic [4:0] CMD_CLEAR_PAGE_BUFFER_BIT = 5'h11;
	// =========================================================
	// address split
	localparam int PAGE_WORDS = 32;
	localparam int WORD_BITS = 5;
	localparam int PAGE_LSB = WORD_BITS + 1;
	localparam logic [15:0] ADDR_FUSE_LO = 16'h0000;
	localparam logic [15:0] ADDR_LOCK = 16'h0001;
	localparam logic [15:0] ADDR_FUSE_EXT = 16'h0002;
	localparam logic [15:0] ADDR_FUSE_HI = 16'h0003;
	// =========================================================
	// arming windows and timing
	localparam logic [2:0] STORE_WIN = 3'h4;
	localparam logic [2:0] READ_WIN = 3'h3;
	localparam int CLK_KHZ = 40000;
	localparam int PROG_MIN_US = 3700;
	localparam int PROG_MAX_US = 4500;
	localparam int PROG_CYC = (PROG_MIN_US * CLK_KHZ + 999) / 1000;
	localparam logic [7:0] LOCK_UNUSED = 8'hfc;
	typedef enum {ST_IDLE, ST_ARMED, ST_BUSY} spf_state_t;
endpackage

// >>> hdl/spf_buf_if.sv
`timescale 1ns/10ps
interface spf_buf_if;
	logic wr;
	logic clr;
	logic [4:0] widx;
	logic [15:0] wdata;
	logic [511:0] image;
	modport ctl (output wr, output clr, output widx, output wdata,
		input image);
	modport buf_side (input wr, input clr, input widx, input wdata,
		output image);
endinterface

// >>> hdl/spf_page_buf.sv
`timescale 1ns/10ps
module spf_page_buf
	import spf_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// buffer port
	spf_buf_if.buf_side bus
);
	typedef struct packed {
		logic [PAGE_WORDS-1:0][15:0] mem;
	} spf_buf_t;
	spf_buf_t st_r, st_nxt;

	// erased flash words read all ones, so clearing fills with ones
	always_comb begin
		st_nxt = st_r;
		if (bus.clr) begin
			st_nxt.mem = '1;
		end else if (bus.wr) begin
			st_nxt.mem[bus.widx] = bus.wdata;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.image = st_r.mem;

	chk_clear_fills: assert property (@(posedge core_clk_i) disable iff (rst_i)
		bus.clr |=> st_r.mem == '1) else $error("buffer not cleared");
endmodule // spf_page_buf

// >>> hdl/spf_sequencer.sv
`timescale 1ns/10ps
module spf_sequencer
	import spf_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC
)
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// control register write and read
	input wire logic ctl_wr_i,
	input wire logic [7:0] ctl_wdata_i,
	output logic [7:0] ctl_rdata_o,
	// cpu instructions
	input wire logic store_i,
	input wire logic table_rd_i,
	input wire logic [15:0] zptr_i,
	input wire logic [15:0] store_data_i,
	input wire logic [15:0] flash_word_i,
	output logic [7:0] table_data_o,
	output logic cpu_stall_o,
	// eeprom status
	input wire logic eeprom_write_busy_i,
	// nonvolatile bits, zero means programmed
	input wire logic [7:0] fuse_low_byte_i,
	input wire logic [7:0] fuse_high_byte_i,
	input wire logic [7:0] fuse_extended_byte_i,
	input wire logic lock_bit_first_i,
	input wire logic lock_bit_second_i,
	// flash array side
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [15:0] flash_page_addr_o,
	output logic [511:0] flash_page_data_o,
	input wire logic flash_por_i
);
	// =========================================================
	// state
	typedef struct packed {
		spf_state_t st;
		logic [4:0] ctl;
		logic [2:0] win;
		logic is_write;
		logic loading;
		logic [31:0] cnt;
		logic [15:0] page;
		logic [7:0] rdata;
		logic stall;
		logic go_erase;
		logic go_write;
	} spf_seq_t;
	spf_seq_t st_r, st_nxt;
	logic [15:0] busy_cnt_r;

	spf_buf_if bif();
	spf_page_buf u_buf (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.bus(bif.buf_side)
	);

	logic cmd_ok;
	logic [4:0] cmd;
	logic [7:0] fuse_sel;
	logic armed_rd;

	// decode written command; only five codes are accepted
	always_comb begin
		cmd = ctl_wdata_i[4:0];
		cmd_ok = (cmd == CMD_LOAD) || (cmd == CMD_ERASE) ||
			(cmd == CMD_WRITE) || (cmd == CMD_READ_FUSE_LOCK_BIT) ||
			(cmd == CMD_CLEAR_PAGE_BUFFER_BIT);
		armed_rd = (st_r.st == ST_ARMED) && st_r.ctl[CTL_READ_FUSE_LOCK_BIT];
		// pick byte by pointer, upper lock bits read one
		case (zptr_i)
			ADDR_FUSE_LO: fuse_sel = fuse_low_byte_i;
			ADDR_LOCK: fuse_sel = {LOCK_UNUSED[7:2], lock_bit_second_i,
				lock_bit_first_i};
			ADDR_FUSE_EXT: fuse_sel = fuse_extended_byte_i;
			ADDR_FUSE_HI: fuse_sel = fuse_high_byte_i;
			default: fuse_sel = LOCK_UNUSED | 8'h03;
		endcase
	end

	// main sequencer
	always_comb begin
		st_nxt = st_r;
		st_nxt.go_erase = 1'b0;
		st_nxt.go_write = 1'b0;
		bif.wr = 1'b0;
		bif.clr = 1'b0;
		bif.widx = zptr_i[WORD_BITS:1];
		bif.wdata = store_data_i;
		// eeprom write while loading loses loaded words
		if (eeprom_write_busy_i && st_r.loading) begin
			bif.clr = 1'b1;
			st_nxt.loading = 1'b0;
		end
		// table read data: armed fuse read or plain byte read
		if (table_rd_i) begin
			if (armed_rd && !eeprom_write_busy_i) begin
				st_nxt.rdata = fuse_sel;
			end else if (zptr_i[0]) begin
				st_nxt.rdata = flash_word_i[15:8];
			end else begin
				st_nxt.rdata = flash_word_i[7:0];
			end
		end
		case (st_r.st)
			ST_IDLE: begin
				if (ctl_wr_i && cmd_ok && !eeprom_write_busy_i) begin
					if (cmd == CMD_CLEAR_PAGE_BUFFER_BIT) begin
						bif.clr = 1'b1;
						st_nxt.loading = 1'b0;
					end
					st_nxt.st = ST_ARMED;
					st_nxt.ctl = cmd;
					st_nxt.win = (cmd == CMD_READ_FUSE_LOCK_BIT) ? READ_WIN : STORE_WIN;
				end
			end
			ST_ARMED: begin
				if (eeprom_write_busy_i) begin
					st_nxt.st = ST_IDLE;
					st_nxt.ctl = '0;
				end else if (table_rd_i && st_r.ctl[CTL_READ_FUSE_LOCK_BIT]) begin
					st_nxt.st = ST_IDLE;
					st_nxt.ctl = '0;
				end else if (store_i) begin
					st_nxt.st = ST_IDLE;
					st_nxt.ctl = '0;
					if (st_r.ctl == CMD_LOAD) begin
						bif.wr = 1'b1;
						st_nxt.loading = 1'b1;
					end else if (st_r.ctl == CMD_ERASE ||
						st_r.ctl == CMD_WRITE) begin
						st_nxt.st = ST_BUSY;
						st_nxt.ctl = st_r.ctl;
						st_nxt.is_write = (st_r.ctl == CMD_WRITE);
						st_nxt.go_erase = (st_r.ctl == CMD_ERASE);
						st_nxt.go_write = (st_r.ctl == CMD_WRITE);
						st_nxt.page = {zptr_i[15:PAGE_LSB],
							{PAGE_LSB{1'b0}}};
						st_nxt.cnt = '0;
						st_nxt.stall = 1'b1;
					end
				end else if (st_r.win == 3'h1) begin
					st_nxt.st = ST_IDLE;
					st_nxt.ctl = '0;
				end else begin
					st_nxt.win = st_r.win - 3'h1;
				end
			end
			ST_BUSY: begin
				st_nxt.cnt = st_r.cnt + 32'h1;
				if (st_r.cnt == 32'(PROG_CYCLES - 1)) begin
					st_nxt.st = ST_IDLE;
					st_nxt.ctl = '0;
					st_nxt.stall = 1'b0;
					if (st_r.is_write) begin
						bif.clr = 1'b1;
						st_nxt.loading = 1'b0;
					end
				end
			end
			default: st_nxt.st = ST_IDLE;
		endcase
	end

	// reset ends commands and the stall, but does not stop the completion timer of a running flash erase or write
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.st <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// independent completion timer, kept off the system reset
	always_ff @(posedge core_clk_i or posedge flash_por_i) begin
		if (flash_por_i) begin
			busy_cnt_r <= '0;
		end else if (st_nxt.go_erase || st_nxt.go_write) begin
			busy_cnt_r <= 16'h1;
		end else if (busy_cnt_r != 16'h0) begin
			busy_cnt_r <= busy_cnt_r + 16'h1;
		end
	end

	assign ctl_rdata_o = {3'h0, st_r.ctl};
	assign table_data_o = st_r.rdata;
	assign cpu_stall_o = st_r.stall;
	assign flash_erase_o = st_r.go_erase;
	assign flash_write_o = st_r.go_write;
	assign flash_page_addr_o = st_r.page;
	assign flash_page_data_o = bif.image;

	// =========================================================
	// checks
	chk_store_window: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(st_r.st == ST_IDLE && ctl_wr_i && ctl_wdata_i[4:0] == CMD_WRITE
		&& !eeprom_write_busy_i) ##1 (!store_i && !table_rd_i
		&& !eeprom_write_busy_i && !ctl_wr_i)[*4] |=> ctl_rdata_o == 8'h00)
		else $error("arming not dropped");
	chk_write_stall: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		flash_write_o |-> cpu_stall_o) else $error("no stall");
	chk_bad_cmd: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(st_r.st == ST_IDLE && ctl_wr_i && !cmd_ok) |=> st_r.st == ST_IDLE)
		else $error("bad code armed");
	chk_ee_block: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(st_r.st == ST_IDLE && eeprom_write_busy_i) |=>
		st_r.st == ST_IDLE) else $error("armed while eeprom busy");
	chk_lock_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(armed_rd && table_rd_i && !eeprom_write_busy_i
		&& zptr_i == ADDR_LOCK) |=> table_data_o[7:2] == 6'h3f)
		else $error("lock upper bits");
	chk_plain_read: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(st_r.st == ST_IDLE && table_rd_i && zptr_i[0]) |=>
		table_data_o == $past(flash_word_i[15:8]))
		else $error("byte select wrong");
	chk_read_clears: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		(armed_rd && table_rd_i) |=> st_r.st == ST_IDLE)
		else $error("read arming held");
	chk_busy_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(cpu_stall_o) |-> ctl_rdata_o[0] throughout cpu_stall_o[*8])
		else $error("enable dropped while busy");
	cov_load: cover property (@(posedge core_clk_i) bif.wr);
	cov_write: cover property (@(posedge core_clk_i) flash_write_o);
	cov_fuse: cover property (@(posedge core_clk_i) armed_rd && table_rd_i);
endmodule // spf_sequencer

// >>> tb/spf_cpu_model.sv
`timescale 1ns/10ps
// =========================================================
// cpu core: control writes, stores, table reads, code memory
module spf_cpu_model (
	// clock
	input wire logic core_clk_i,
	// instruction side
	output logic ctl_wr_o,
	output logic [7:0] ctl_wdata_o,
	output logic store_o,
	output logic table_rd_o,
	output logic [15:0] zptr_o,
	output logic [15:0] store_data_o,
	output logic [15:0] flash_word_o
);
	// code memory pattern keyed by word address, never constant
	assign flash_word_o = {zptr_o[8:1] ^ 8'ha5, zptr_o[8:1]};
	initial begin
		ctl_wr_o = 1'b0;
		ctl_wdata_o = 8'h00;
		store_o = 1'b0;
		table_rd_o = 1'b0;
		zptr_o = 16'h0000;
		store_data_o = 16'h0000;
	end
	// arm, wait gap cycles, then store (0), table read (1) or nothing
	task automatic run(input logic [7:0] cmd, input logic [15:0] z,
		input logic [15:0] d, input int gap, input int kind);
		@(negedge core_clk_i);
		zptr_o = z;
		store_data_o = d;
		ctl_wdata_o = cmd;
		ctl_wr_o = 1'b1;
		@(negedge core_clk_i);
		ctl_wr_o = 1'b0;
		repeat (gap) @(negedge core_clk_i);
		store_o = (kind == 0);
		table_rd_o = (kind == 1);
		@(negedge core_clk_i);
		store_o = 1'b0;
		table_rd_o = 1'b0;
	endtask
endmodule // spf_cpu_model

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import spf_pkg::*;
	logic core_clk_i = 1'b0, rst_i = 1'b1, flash_por_i = 1'b1;
	logic ctl_wr, store, trd, ee_busy = 1'b0;
	logic [7:0] fuse_lo = 8'h62;
	logic [7:0] ctl_wdata, ctl_rdata, tdata;
	logic [15:0] zptr, sdata, fword, paddr;
	logic stall, f_erase, f_write;
	logic [511:0] pdata;
	int n_errors = 0, n_tests = 0;
	// =========================================================
	// clock and parts
	always #12.5 core_clk_i = ~core_clk_i;
	spf_cpu_model i_cpu (.core_clk_i(core_clk_i), .ctl_wr_o(ctl_wr),
		.ctl_wdata_o(ctl_wdata), .store_o(store), .table_rd_o(trd),
		.zptr_o(zptr), .store_data_o(sdata), .flash_word_o(fword));
	spf_sequencer #(.PROG_CYCLES(20)) i_dut (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .ctl_wr_i(ctl_wr), .ctl_wdata_i(ctl_wdata),
		.ctl_rdata_o(ctl_rdata), .store_i(store), .table_rd_i(trd),
		.zptr_i(zptr), .store_data_i(sdata), .flash_word_i(fword),
		.table_data_o(tdata), .cpu_stall_o(stall),
		.eeprom_write_busy_i(ee_busy), .fuse_low_byte_i(fuse_lo),
		.fuse_high_byte_i(8'hdf), .fuse_extended_byte_i(8'hfe),
		.lock_bit_first_i(1'b0), .lock_bit_second_i(1'b1),
		.flash_erase_o(f_erase), .flash_write_o(f_write),
		.flash_page_addr_o(paddr), .flash_page_data_o(pdata),
		.flash_por_i(flash_por_i));
	// =========================================================
	// shared checking
	task automatic check(input logic [511:0] seen, input logic [511:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// count cycles until the stall drops, bounded
	task automatic wait_stall(output int n);
		n = 0;
		while (stall === 1'b1 && n < 1000) begin
			n++;
			@(negedge core_clk_i);
		end
	endtask
	task automatic summarize();
		$display("errors=%0d tests=%0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// =========================================================
	// scenarios
	task automatic t_write();
		logic [511:0] img;
		int n;
		img = '1;
		img[15:0] = 16'h1234;
		img[511:496] = 16'habcd;
		i_cpu.run(8'h01, 16'h0000, 16'h1234, 0, 0);
		i_cpu.run(8'h01, 16'h003e, 16'habcd, 2, 0);
		check(pdata, img);
		i_cpu.run(8'h05, 16'h0140, 16'h5a5a, 0, 0);
		check(stall, 1'b1);
		check(f_write, 1'b1);
		check(paddr, 16'h0140);
		check(ctl_rdata[0], 1'b1);
		wait_stall(n);
		check(n, 20);
		check(pdata, '1);
		i_cpu.run(8'h03, 16'h0140, 16'h0000, 1, 0);
		check(f_erase, 1'b1);
		wait_stall(n);
		check(n, 20);
	endtask
	task automatic t_clear();
		i_cpu.run(8'h01, 16'h000a, 16'h4321, 0, 0);
		i_cpu.run(8'h11, 16'h0000, 16'h0000, 0, 0);
		check(pdata, '1);
		i_cpu.run(8'h01, 16'h0004, 16'h7777, 5, 0);
		check(pdata, '1);
		i_cpu.run(8'h07, 16'h0004, 16'h7777, 0, 0);
		check(stall, 1'b0);
		check(ctl_rdata, 8'h00);
		check(pdata, '1);
	endtask
	task automatic t_eeprom();
		i_cpu.run(8'h01, 16'h0002, 16'h5555, 0, 0);
		ee_busy = 1'b1;
		@(negedge core_clk_i);
		check(pdata, '1);
		i_cpu.run(8'h01, 16'h0002, 16'h5555, 0, 0);
		check(ctl_rdata, 8'h00);
		check(pdata, '1);
		ee_busy = 1'b0;
	endtask
	task automatic t_fuse();
		logic [7:0] exp [4];
		exp = '{8'h62, 8'hfe, 8'hfe, 8'hdf};
		for (int a = 0; a < 4; a++) begin
			i_cpu.run(8'h09, 16'(a), 16'h0000, a % 3, 1);
			check(tdata, exp[a]);
			check(ctl_rdata, 8'h00);
		end
		// a second fuse pattern proves the byte is passed, not fixed
		fuse_lo = 8'h9d;
		i_cpu.run(8'h09, 16'h0000, 16'h0000, 0, 1);
		check(tdata, 8'h9d);
		i_cpu.run(8'h00, 16'h0053, 16'h0000, 0, 1);
		check(tdata, 8'h8c);
		i_cpu.run(8'h00, 16'h0052, 16'h0000, 0, 1);
		check(tdata, 8'h29);
	endtask
	// =========================================================
	// main sequence and watchdog
	initial begin
		repeat (4) @(negedge core_clk_i);
		rst_i = 1'b0;
		flash_por_i = 1'b0;
		check(pdata, '1);
		t_write();
		t_clear();
		t_eeprom();
		t_fuse();
		summarize();
	end
	initial begin
		#100000;
		n_errors++;
		summarize();
	end
endmodule // testbench
